// ### logic/canmc_defines.svh
`ifndef CANMC_DEFINES_SVH
`define CANMC_DEFINES_SVH
// Transceiver mode codes, two bits
`define CANMC_MODE_OFF     2'h0
`define CANMC_MODE_WAKE    2'h1
`define CANMC_MODE_NORMAL  2'h2
`define CANMC_MODE_RXONLY  2'h3
// Supervisor operating mode codes
`define CANMC_SUP_NORMAL   3'h0
`define CANMC_SUP_STOP     3'h1
`define CANMC_SUP_SLEEP    3'h2
`define CANMC_SUP_RESTART  3'h3
`define CANMC_SUP_FAILSAFE 3'h4
// Timing, clock rate and filter times
`define CANMC_CLK_HZ       50000000
`define CANMC_EN_TIME_NS   10000
`define CANMC_WAKE1_NS     1000
`define CANMC_WAKE2_NS     500000
`define CANMC_EN_CYC       ((`CANMC_EN_TIME_NS * 50 + 999) / 1000)
`define CANMC_WAKE1_CYC    ((`CANMC_WAKE1_NS * 50 + 999) / 1000)
`define CANMC_WAKE2_CYC    ((`CANMC_WAKE2_NS * 50) / 1000)
`endif

// ### logic/canmc_pkg.sv
package canmc_pkg;
   typedef logic [1:0] canmc_mode_t;
   typedef logic [2:0] canmc_sup_t;
   typedef enum logic [3:0] {
      WK_IDLE = 4'h1,
      WK_DOM1 = 4'h2,
      WK_REC  = 4'h4,
      WK_DOM2 = 4'h8
   } canmc_wk_e;
endpackage

// ### logic/canmc_wake_if.sv
`timescale 1ns/1ps
interface canmc_wake_if;
   logic armed;
   logic bus_dom;
   logic wake;
   modport ctrl (output armed, output bus_dom, input wake);
   modport det  (input armed, input bus_dom, output wake);
endinterface

// ### logic/canmc_wake_det.sv
`timescale 1ns/1ps
`include "canmc_defines.svh"
module canmc_wake_det #(
   parameter int W1_CYC = `CANMC_WAKE1_CYC,
   parameter int W2_CYC = `CANMC_WAKE2_CYC
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic ce_i,
   canmc_wake_if.det wif
);
   import canmc_pkg::*;
   localparam int CW = $clog2(W2_CYC + 2);
   canmc_wk_e       st_reg, st_next;
   logic [CW-1:0]   cnt_reg, cnt_next;
   logic            wake_reg, wake_next;

   // Two long dominant phases split by a short recessive gap
   always_comb begin
      st_next   = st_reg;
      cnt_next  = cnt_reg;
      wake_next = 1'b0;
      if (!wif.armed) begin
         st_next  = WK_IDLE;
         cnt_next = '0;
      end else begin
         unique case (st_reg)
            WK_IDLE: begin
               cnt_next = '0;
               if (wif.bus_dom) st_next = WK_DOM1;
            end
            WK_DOM1: begin
               if (!wif.bus_dom) begin
                  st_next  = (int'(cnt_reg) >= W1_CYC) ? WK_REC : WK_IDLE; // [R17]
                  cnt_next = '0;
               end else if (int'(cnt_reg) < W1_CYC) begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            WK_REC: begin
               if (wif.bus_dom) begin
                  st_next  = WK_DOM2;
                  cnt_next = '0;
               end else if (int'(cnt_reg) + 1 >= W2_CYC) begin
                  st_next  = WK_IDLE; // Gap too long [R17]
                  cnt_next = '0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            WK_DOM2: begin
               if (!wif.bus_dom) begin
                  st_next  = WK_IDLE;
                  cnt_next = '0;
               end else if (int'(cnt_reg) >= W1_CYC) begin
                  wake_next = 1'b1; // Second phase long enough [R17]
                  st_next   = WK_IDLE;
                  cnt_next  = '0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_reg   <= WK_IDLE;
         cnt_reg  <= '0;
         wake_reg <= 1'b0;
      end else if (ce_i) begin
         st_reg   <= st_next;
         cnt_reg  <= cnt_next;
         wake_reg <= wake_next;
      end
   end

   assign wif.wake = wake_reg & ce_i;
endmodule

// ### logic/canmc_top.sv
// Contract
// R1: After power-up the transceiver stays Off until software picks a mode.
// R2: Off can be chosen in every supervisor mode and stops bus activity.
// R3: In Off the bus pins are high impedance, no driver, no bias.
// R4: In Off, bus wake messages are ignored and never recorded.
// R5: Software enables Normal through the control port in supervisor Normal.
// R6: Normal mode only while supervisor is in Normal or Stop.
// R7: Normal and Receive Only bias the bus to half supply.
// R8: Normal drives dominant for low transmit input, recessive for high.
// R9: Controller keeps transmit high until the enable time has passed.
// R10: Dominant begun before enable time ends is not driven; wait recessive.
// R11: Receive output is low for dominant bus, high for recessive.
// R12: Receive Only disables the driver while reception continues.
// R13: Receive Only selectable in supervisor Normal or Stop.
// R14: Path supports up to 2 Mbaud including fast data phase.
// R15: Active mode comes from mode bits written through the control port.
// R16: Wake Capable turns a valid bus wake message into a wake event.
// R17: Wake needs two long dominant phases split by a short recessive gap.
// R18: After a wake, receive output stays low until mode changes.
// R19: Mode bits still read Wake Capable after wake; rearm by toggling.
// R20: Mode field two bits; Off, Normal, Receive Only codes differ from Wake.
// R21: Enable time counted by a timer started on entry to Normal.
`timescale 1ns/1ps
`include "canmc_defines.svh"
module canmc_top #(
   parameter int EN_CYC = `CANMC_EN_CYC,
   parameter int W1_CYC = `CANMC_WAKE1_CYC,
   parameter int W2_CYC = `CANMC_WAKE2_CYC
) (
   input  wire logic                  CLK_I,
   input  wire logic                  RESET_I,
   input  wire logic                  CE_I,
   input  wire canmc_pkg::canmc_mode_t MODE_WR_I,
   input  wire logic                  MODE_WE_I,
   input  wire canmc_pkg::canmc_sup_t SUP_MODE_I,
   input  wire logic                  CAN_TRANSMIT_INPUT_I,
   input  wire logic                  BUS_DOM_I,
   output      canmc_pkg::canmc_mode_t MODE_RD_O,
   output      logic                  RECEIVE_O,
   output      logic                  DRV_DOM_O,
   output      logic                  BIAS_HALF_O,
   output      logic                  BUS_HIZ_O,
   output      logic                  WAKE_EVENT_O,
   output      logic                  WOKEN_O
);
   import canmc_pkg::*;
   localparam int EW = $clog2(EN_CYC + 2);

   canmc_mode_t   mode_reg, mode_next;
   logic [EW-1:0] en_cnt_reg, en_cnt_next;
   logic          tx_ok_reg, tx_ok_next;
   logic          woken_reg, woken_next;
   logic          wake_ev_reg, wake_ev_next;
   logic          rx_reg, rx_next;
   logic          drv_reg, drv_next;
   logic          bus_s1_reg, bus_s2_reg, bus_s3_reg, bus_reg;
   logic          txd_reg;
   logic          mode_ok;
   canmc_wake_if  wif ();

   // Normal and Receive Only only under supervisor Normal or Stop
   function automatic logic active_allowed(input canmc_sup_t s);
      return (s == `CANMC_SUP_NORMAL) || (s == `CANMC_SUP_STOP);
   endfunction

   // Bus level synchroniser; changes accepted when stages two and three agree
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         bus_s1_reg <= 1'b0;
         bus_s2_reg <= 1'b0;
         bus_s3_reg <= 1'b0;
         bus_reg    <= 1'b0;
         txd_reg    <= 1'b1;
      end else if (CE_I) begin
         bus_s1_reg <= BUS_DOM_I;
         bus_s2_reg <= bus_s1_reg;
         bus_s3_reg <= bus_s2_reg;
         if (bus_s2_reg == bus_s3_reg) bus_reg <= bus_s3_reg;
         txd_reg    <= CAN_TRANSMIT_INPUT_I; // Controller shares this clock
      end
   end

   // Write legality check on the requested mode
   always_comb begin
      unique case (MODE_WR_I)
         `CANMC_MODE_NORMAL, `CANMC_MODE_RXONLY:
            mode_ok = active_allowed(SUP_MODE_I); // [R5] [R6] [R13]
         default: mode_ok = 1'b1; // Off always allowed [R2]
      endcase
   end

   assign wif.armed   = (mode_reg == `CANMC_MODE_WAKE) && !woken_reg; // [R4] [R16]
   assign wif.bus_dom = bus_reg;

   // Mode, enable timer, wake latch and data path next values
   always_comb begin
      mode_next    = mode_reg;
      en_cnt_next  = en_cnt_reg;
      tx_ok_next   = tx_ok_reg;
      woken_next   = woken_reg;
      wake_ev_next = 1'b0;
      if (MODE_WE_I && mode_ok) mode_next = MODE_WR_I; // [R15] [R20]
      // Leaving supervisor Normal/Stop drops an active mode back to Off
      if (!active_allowed(SUP_MODE_I) &&
          (mode_next == `CANMC_MODE_NORMAL || mode_next == `CANMC_MODE_RXONLY))
         mode_next = `CANMC_MODE_OFF; // [R6]
      if (mode_next != mode_reg) woken_next = 1'b0; // Toggle rearms [R19]
      if (wif.wake && wif.armed) begin // Late pulse after a mode change is dropped [R4]
         woken_next   = 1'b1; // Set wins: only cleared on mode change [R16]
         wake_ev_next = 1'b1;
      end
      if (mode_next == `CANMC_MODE_NORMAL && mode_reg != `CANMC_MODE_NORMAL) begin
         en_cnt_next = '0; // Timer restarts on entry [R21]
         tx_ok_next  = 1'b0;
      end else if (mode_reg == `CANMC_MODE_NORMAL) begin
         if (int'(en_cnt_reg) < EN_CYC) en_cnt_next = en_cnt_reg + 1'b1; // [R21]
         // Arm only on a recessive level after the enable time [R10] [R9]
         if (int'(en_cnt_reg) >= EN_CYC && txd_reg) tx_ok_next = 1'b1;
      end else begin
         tx_ok_next = 1'b0;
      end
      // Driver: Normal mode only, direct low-latency path [R8] [R12] [R14]
      drv_next = (mode_reg == `CANMC_MODE_NORMAL) && tx_ok_reg && !txd_reg;
      // Receive: bus follow in Normal/RxOnly, low after wake [R11] [R18]
      unique case (mode_reg)
         `CANMC_MODE_NORMAL, `CANMC_MODE_RXONLY: rx_next = !bus_reg; // [R11] [R12]
         `CANMC_MODE_WAKE: rx_next = !woken_reg; // [R18]
         default: rx_next = 1'b1;
      endcase
   end

   // State registers; reset places the transceiver Off
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         mode_reg    <= `CANMC_MODE_OFF; // [R1]
         en_cnt_reg  <= '0;
         tx_ok_reg   <= 1'b0;
         woken_reg   <= 1'b0;
         wake_ev_reg <= 1'b0;
         rx_reg      <= 1'b1;
         drv_reg     <= 1'b0;
      end else if (CE_I) begin
         mode_reg    <= mode_next;
         en_cnt_reg  <= en_cnt_next;
         tx_ok_reg   <= tx_ok_next;
         woken_reg   <= woken_next;
         wake_ev_reg <= wake_ev_next;
         rx_reg      <= rx_next;
         drv_reg     <= drv_next;
      end
   end

   canmc_wake_det #(
      .W1_CYC (W1_CYC),
      .W2_CYC (W2_CYC)
   ) u_wake (
      .clk_i   (CLK_I),
      .reset_i (RESET_I),
      .ce_i    (CE_I),
      .wif     (wif)
   );

   // Outputs; bias and hi-Z follow the mode register
   assign MODE_RD_O    = mode_reg; // Still reads Wake after wake [R19]
   assign RECEIVE_O    = rx_reg;
   assign DRV_DOM_O    = drv_reg;
   assign BIAS_HALF_O  = (mode_reg == `CANMC_MODE_NORMAL) ||
                         (mode_reg == `CANMC_MODE_RXONLY); // [R7]
   assign BUS_HIZ_O    = (mode_reg == `CANMC_MODE_OFF); // [R3]
   assign WAKE_EVENT_O = wake_ev_reg;
   assign WOKEN_O      = woken_reg;
endmodule

// ### dv/canmc_ctrl_model.sv
`timescale 1ns/1ps
module canmc_ctrl_model #(
   parameter int EN_CYC = 8
) (
   input  wire logic clk_i,
   input  wire logic normal_i,
   input  wire logic early_i,
   input  wire logic want_i,
   output      logic txd_o
);
   int unsigned cnt_reg = 0;
   // Settle count since Normal shows at the mode bits
   always @(posedge clk_i) cnt_reg <= normal_i ? cnt_reg + 1 : 0;
   // Recessive until settled, one spare cycle of margin; early breaks it on purpose
   assign txd_o = (early_i || cnt_reg > EN_CYC + 1) ? want_i : 1'b1;
endmodule

// ### dv/canmc_top_assertions.sv
`timescale 1ns/1ps
module canmc_top_chk #(
   parameter int EN_CYC = 8
) (
   input wire logic                   CLK_I,
   input wire logic                   RESET_I,
   input wire logic                   CAN_TRANSMIT_INPUT_I,
   input wire logic                   BUS_DOM_I,
   input wire logic                   MODE_WE_I,
   input wire canmc_pkg::canmc_mode_t MODE_WR_I,
   input wire canmc_pkg::canmc_sup_t  SUP_MODE_I,
   input wire canmc_pkg::canmc_mode_t MODE_RD_O,
   input wire logic                   RECEIVE_O,
   input wire logic                   DRV_DOM_O,
   input wire logic                   BIAS_HALF_O,
   input wire logic                   BUS_HIZ_O,
   input wire logic                   WAKE_EVENT_O,
   input wire logic                   WOKEN_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   // Entry to Normal, and a wake that stays in force
   sequence s_enter; $rose(MODE_RD_O == 2'h2); endsequence
   sequence s_woke; WOKEN_O && MODE_RD_O == 2'h1 ##1 MODE_RD_O == 2'h1; endsequence
   property p_rst; $fell(RESET_I) |-> MODE_RD_O == 2'h0 && BUS_HIZ_O && RECEIVE_O; endproperty
   a_rst: assert property (p_rst) else $error("not Off after reset");
   property p_off; MODE_RD_O == 2'h0 |-> BUS_HIZ_O && !BIAS_HALF_O; endproperty
   a_off: assert property (p_off) else $error("Off pins not released");
   property p_bias; MODE_RD_O[1] |-> BIAS_HALF_O && !BUS_HIZ_O; endproperty
   a_bias: assert property (p_bias) else $error("no half bias");
   property p_offwr; MODE_WE_I && MODE_WR_I == 2'h0 |=> MODE_RD_O == 2'h0; endproperty
   a_offwr: assert property (p_offwr) else $error("Off write lost");
   property p_ill;
      MODE_WE_I && MODE_WR_I[1] && SUP_MODE_I > 3'h1 && !MODE_RD_O[1] |=> !MODE_RD_O[1];
   endproperty
   a_ill: assert property (p_ill) else $error("illegal mode taken");
   property p_hold; s_enter |-> !DRV_DOM_O [*8]; endproperty
   a_hold: assert property (p_hold) else $error("drive before settle");
   property p_drv; DRV_DOM_O |-> !$past(CAN_TRANSMIT_INPUT_I, 2); endproperty
   a_drv: assert property (p_drv) else $error("dominant without cause");
   property p_rx;
      (MODE_RD_O == 2'h3 && $stable(BUS_DOM_I)) [*7] |-> RECEIVE_O == !BUS_DOM_I && !DRV_DOM_O;
   endproperty
   a_rx: assert property (p_rx) else $error("receive-only path wrong");
   property p_wev; WAKE_EVENT_O |-> MODE_RD_O == 2'h1; endproperty
   a_wev: assert property (p_wev) else $error("wake outside wake mode");
   property p_woke; s_woke |-> !RECEIVE_O; endproperty
   a_woke: assert property (p_woke) else $error("receive not held low");
endmodule
bind canmc_top canmc_top_chk #(.EN_CYC(EN_CYC)) chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I),
   .CAN_TRANSMIT_INPUT_I(CAN_TRANSMIT_INPUT_I), .BUS_DOM_I(BUS_DOM_I), .MODE_WE_I(MODE_WE_I),
   .MODE_WR_I(MODE_WR_I), .SUP_MODE_I(SUP_MODE_I), .MODE_RD_O(MODE_RD_O), .RECEIVE_O(RECEIVE_O),
   .DRV_DOM_O(DRV_DOM_O), .BIAS_HALF_O(BIAS_HALF_O), .BUS_HIZ_O(BUS_HIZ_O),
   .WAKE_EVENT_O(WAKE_EVENT_O), .WOKEN_O(WOKEN_O));

// ### dv/canmc_top_tb.sv
`timescale 1ns/1ps
`include "canmc_defines.svh"
module canmc_top_tb;
   logic                   clk = 1'b0;
   logic                   rst, we, early, want, bus_dom, txd, rx, drv, bias, hiz, wev, woken, got;
   canmc_pkg::canmc_mode_t mwr, rd;
   canmc_pkg::canmc_sup_t  sup;
   int                     error_cnt, checks_done;
   // Short counts keep the run brief
   canmc_top #(.EN_CYC(8), .W1_CYC(4), .W2_CYC(20)) dut_u (.CLK_I(clk), .RESET_I(rst),
      .CE_I(1'b1), .MODE_WR_I(mwr), .MODE_WE_I(we), .SUP_MODE_I(sup),
      .CAN_TRANSMIT_INPUT_I(txd), .BUS_DOM_I(bus_dom), .MODE_RD_O(rd), .RECEIVE_O(rx),
      .DRV_DOM_O(drv), .BIAS_HALF_O(bias), .BUS_HIZ_O(hiz), .WAKE_EVENT_O(wev), .WOKEN_O(woken));
   canmc_ctrl_model #(.EN_CYC(8)) ctl_u (.clk_i(clk), .normal_i(rd == `CANMC_MODE_NORMAL),
      .early_i(early), .want_i(want), .txd_o(txd));
   always #10 clk = ~clk;
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input canmc_pkg::canmc_mode_t m);
      mwr = m;
      we = 1'b1;
      step(1);
      we = 1'b0;
      step(1);
   endtask
   // A dominant phase of d cycles, a recessive gap of r cycles, then d+8 dominant cycles watched for a wake event
   task automatic wake_seq(input int d, input int r);
      got = 1'b0;
      bus_dom = 1'b1;
      step(d);
      bus_dom = 1'b0;
      step(r);
      bus_dom = 1'b1;
      repeat (d + 8) begin
         step(1);
         if (wev === 1'b1) got = 1'b1;
      end
      bus_dom = 1'b0;
      step(30); // Gap beyond the recessive limit so the tail cannot pair with the next call
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #60000;
      error_cnt++;
      results;
   end
   initial begin
      rst = 1'b1;
      {we, mwr, early, want, bus_dom} = 6'h00;
      error_cnt = 0;
      checks_done = 0;
      sup = `CANMC_SUP_NORMAL;
      step(2);
      rst = 1'b0;
      step(1);
      chk(rd, `CANMC_MODE_OFF);
      chk({hiz, bias}, 2'h2);
      wake_seq(6, 5);
      chk({got, woken}, 2'h0);
      $display("off test done");
      sup = `CANMC_SUP_SLEEP;
      wr(`CANMC_MODE_NORMAL);
      wr(`CANMC_MODE_RXONLY);
      chk(rd, `CANMC_MODE_OFF);
      sup = `CANMC_SUP_STOP;
      wr(`CANMC_MODE_RXONLY);
      chk(rd, `CANMC_MODE_RXONLY);
      chk({hiz, bias}, 2'h1);
      {early, want, bus_dom} = 3'h5;
      step(8);
      chk({rx, drv}, 2'h0);
      bus_dom = 1'b0;
      step(8);
      chk(rx, 1'b1);
      $display("receive only test done");
      sup = `CANMC_SUP_NORMAL;
      wr(`CANMC_MODE_NORMAL);
      step(12);
      chk(drv, 1'b0);
      want = 1'b1;
      step(3);
      want = 1'b0;
      step(3);
      chk(drv, 1'b1);
      want = 1'b1;
      step(3);
      chk(drv, 1'b0);
      {early, want} = 2'h0;
      wr(`CANMC_MODE_OFF);
      wr(`CANMC_MODE_NORMAL);
      step(14);
      chk(drv, 1'b1);
      sup = `CANMC_SUP_SLEEP;
      want = 1'b1;
      step(2);
      chk(rd, `CANMC_MODE_OFF);
      $display("normal test done");
      wr(`CANMC_MODE_WAKE);
      wake_seq(3, 5);
      chk(got, 1'b0);
      wake_seq(6, 25);
      chk(got, 1'b0);
      wake_seq(6, 5);
      chk({got, woken}, 2'h3);
      chk({rx, rd}, {1'b0, `CANMC_MODE_WAKE});
      wake_seq(6, 5);
      chk(got, 1'b0);
      sup = `CANMC_SUP_FAILSAFE;
      wr(`CANMC_MODE_OFF);
      chk({woken, rx}, 2'h1);
      wr(`CANMC_MODE_WAKE);
      wake_seq(6, 5);
      chk(got, 1'b1);
      $display("wake test done");
      results;
   end
endmodule
